// [rtl/pit_pkg.sv]
package pit_pkg;

  // ----------------------------------------
  // host i/o port map
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] CTR0_PORT = 16'h0040; // counter 0 data
  localparam logic [15:0] CTR1_PORT = 16'h0041; // counter 1 data
  localparam logic [15:0] CTR2_PORT = 16'h0042; // counter 2 data
  localparam logic [15:0] CTRL_PORT = 16'h0043; // control word, write only

  // ----------------------------------------
  // control word fields
  // ----------------------------------------
  localparam int CW_SEL_LO = 6; // counter select, two bits
  localparam int CW_ACC_LO = 4; // access format, two bits
  localparam int CW_MODE_LO = 1; // mode, three bits
  localparam int CW_BCD_BIT = 0; // bcd select
  localparam int RB_COUNT_N_BIT = 5; // count_capture_select_n
  localparam int RB_STATUS_N_BIT = 4; // status_capture_select_n
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LSB = 2'h1;
  localparam logic [1:0] ACC_MSB = 2'h2;
  localparam logic [1:0] ACC_WORD = 2'h3;

  // ----------------------------------------
  // modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_TC = 3'b000, // terminal-count interrupt
    MODE_ONESHOT = 3'b001, // retriggerable one-shot
    MODE_RATE = 3'b010, // rate generator
    MODE_SQUARE = 3'b011, // square wave
    MODE_SWSTROBE = 3'b100, // software-triggered strobe
    MODE_HWSTROBE = 3'b101 // hardware-triggered strobe
  } mode_t;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [1:0] RST_ACCESS = 2'h1;
  localparam logic RST_OUT = 1'b0;
  localparam int TICK_DIV = 12; // oscillator edges per timer tick

  // subtract step from the counting element, binary or four bcd digits
  function automatic logic [15:0] ce_sub(input logic [15:0] v, input logic bcd,
                                         input logic [1:0] step);
    logic [15:0] r;
    logic [4:0] d;
    logic [1:0] b;
    r = v - {14'h0000, step};
    b = step;
    if (bcd)
    begin
      for (int k = 0; k < 4; k++)
      begin
        d = {1'b0, v[4*k +: 4]} - {3'b000, b};
        b = {1'b0, d[4]};
        if (d[4])
          d = d + 5'h0a;
        r[4*k +: 4] = d[3:0];
      end
    end
    return r;
  endfunction

endpackage

// [rtl/pit_tick.sv]
`timescale 1ns/10ps
`default_nettype none
module pit_tick
#(
  parameter int DIV = pit_pkg::TICK_DIV
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic oscillator_input,
  output logic timer_tick_clock,
  output logic tick_rise,
  output logic tick_fall
);
  import pit_pkg::*;

  // ----------------------------------------
  // oscillator divider
  // ----------------------------------------
  localparam logic [7:0] HALF = 8'(DIV / 2); // edges per tick half
  logic osc_prev_reg; // last oscillator level
  logic [7:0] edge_cnt_reg; // oscillator edges in this half
  logic osc_edge; // rising oscillator edge

  assign osc_edge = oscillator_input && !osc_prev_reg;

  // count oscillator edges, toggle the tick every half period
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      osc_prev_reg <= 1'b0;
      edge_cnt_reg <= 8'h00;
      timer_tick_clock <= 1'b0;
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
    end
    else
    begin
      osc_prev_reg <= oscillator_input;
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
      if (osc_edge)
      begin
        if (edge_cnt_reg == HALF - 8'h01)
        begin
          edge_cnt_reg <= 8'h00;
          timer_tick_clock <= !timer_tick_clock;
          tick_rise <= !timer_tick_clock;
          tick_fall <= timer_tick_clock;
        end
        else
          edge_cnt_reg <= edge_cnt_reg + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/pit_top.sv]
// How it works
// - three 16-bit counters, binary or bcd
// - shared tick is oscillator divided by twelve
// - counter 0 output drives interrupt request
// - counters 0 and 1 gates tied low
// - load or decrement on tick falling edge
// - loaded zero counts as maximum
// - zero reloads in modes 2-3, else wraps
// - count bytes land in input latches first
// - reads come from transparent or frozen latches
// - ports 40-42 data, 43 control
// - new count accepted anytime after programming
// - latch command freezes count until read
// - repeated latch before read is ignored
// - read-back captures count, mode, output, null
// - status read first, then count bytes
// - repeated read-back before read is ignored
// - gate rising edge triggers, load moves latches
// - six counting modes supported
// - terminal mode: low on write, high after N+1
// - odd square wave: high (N+1)/2, low (N-1)/2
// - low counter 2 gate stops rate/square and forces high
`timescale 1ns/10ps
`default_nettype none
module pit_top
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic OSCILLATOR_INPUT,
  input wire logic [pit_pkg::ADDR_W-1:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic IO_RACK,
  input wire logic COUNTER2_GATE,
  output logic COUNTER0_OUTPUT,
  output logic COUNTER1_OUTPUT,
  output logic COUNTER2_OUTPUT,
  output logic TIMER_TICK_CLOCK
);
  import pit_pkg::*;

  // ----------------------------------------
  // shared tick and control decode
  // ----------------------------------------
  logic tick_rise; // tick rising edge, one clk
  logic tick_fall; // tick falling edge, one clk
  logic cw_wr; // write to control port
  logic [1:0] cw_sel; // control word counter select
  logic [1:0] cw_acc; // control word access field
  logic [7:0] rd_byte [3]; // per-counter read data
  logic [2:0] out_w; // per-counter output level

  pit_tick #(.DIV(TICK_DIV)) u_tick
  (
    .clk(CLK),
    .sys_rst(SYS_RST),
    .oscillator_input(OSCILLATOR_INPUT),
    .timer_tick_clock(TIMER_TICK_CLOCK),
    .tick_rise(tick_rise),
    .tick_fall(tick_fall)
  );

  assign cw_wr = IO_WR && (IO_ADDR == CTRL_PORT);
  assign cw_sel = IO_WDATA[CW_SEL_LO +: 2];
  assign cw_acc = IO_WDATA[CW_ACC_LO +: 2];

  // modes 6 and 7 alias rate and square
  function automatic mode_t norm_mode(input logic [2:0] m);
    return mode_t'(m[1] ? {1'b0, m[1:0]} : m);
  endfunction

  // ----------------------------------------
  // three counters
  // ----------------------------------------
  for (genvar i = 0; i < 3; i++)
  begin : g_ctr
    // configuration and host latches
    mode_t mode_reg; // programmed mode
    logic bcd_reg; // bcd counting
    logic [1:0] acc_reg; // access format
    logic [7:0] lo_reg; // input_latch_low
    logic [7:0] hi_reg; // input_latch_high
    logic wflip_reg; // second write byte due
    logic rflip_reg; // second read byte due
    logic prog_reg; // count written since control word
    logic [15:0] ol_reg; // frozen output latches
    logic cl_reg; // count latched
    logic sl_reg; // status latched
    logic [7:0] st_reg; // latched status byte
    // counting element
    logic [15:0] count_reg; // counting element
    logic out_reg; // counter output
    logic null_reg; // null count flag
    logic newc_reg; // new count waiting for load
    logic run_reg; // element loaded and counting
    logic armed_reg; // strobe pulse still pending
    logic gpre_reg; // previous gate level
    logic gate_s_reg; // gate sampled at tick rise
    logic tpend_reg; // trigger seen, not yet sampled
    logic trig_reg; // sampled trigger for next fall
    // decode and next-state helpers
    logic data_hit; // address hits this data port
    logic wr_hit; // data write
    logic rd_hit; // data read
    logic prog_cw; // control word programs this counter
    logic latch_cmd; // counter latch command
    logic rb_hit; // read-back selects this counter
    logic write_done; // full count written
    logic gate_raw; // gate level at the pin
    logic gate_en; // level enable for counting
    logic [1:0] step; // decrement size
    logic [15:0] nxt; // decremented value
    logic [15:0] reload_pt; // count at which reload happens
    logic load_now; // counter load this clk
    logic dec_now; // decrement this clk
    logic [15:0] src; // transparent or frozen count

    assign data_hit = (IO_ADDR == 16'(CTR0_PORT + i));
    assign wr_hit = IO_WR && data_hit;
    assign rd_hit = IO_RD && data_hit;
    assign prog_cw = cw_wr && (cw_sel == 2'(i)) && (cw_acc != ACC_LATCH);
    assign latch_cmd = cw_wr && (cw_sel == 2'(i)) && (cw_acc == ACC_LATCH);
    assign rb_hit = cw_wr && (cw_sel == SEL_READBACK) && IO_WDATA[CW_MODE_LO + i];
    assign write_done = wr_hit && prog_reg_ok() && (acc_reg != ACC_WORD || wflip_reg);
    // counters 0 and 1 see no gate edge; level does not block them
    assign gate_raw = (i == 2) ? COUNTER2_GATE : 1'b0;
    assign gate_en = (i == 2) ? gate_s_reg : 1'b1;

    // data writes count whenever the access format is not latch, including straight after reset
    function automatic logic prog_reg_ok();
      return acc_reg != ACC_LATCH;
    endfunction

    // host side: control word, input latches, output latches
    always_ff @(posedge CLK)
    begin
      if (SYS_RST)
      begin
        mode_reg <= MODE_TC;
        bcd_reg <= 1'b0;
        acc_reg <= RST_ACCESS;
        lo_reg <= 8'h00;
        hi_reg <= 8'h00;
        wflip_reg <= 1'b0;
        rflip_reg <= 1'b0;
        prog_reg <= 1'b0;
        ol_reg <= RST_COUNT;
        cl_reg <= 1'b0;
        sl_reg <= 1'b0;
        st_reg <= 8'h00;
      end
      else
      begin
        // data port read: status first, then count bytes
        if (rd_hit)
        begin
          if (sl_reg)
            sl_reg <= 1'b0;
          else
          begin
            if (acc_reg == ACC_WORD)
              rflip_reg <= !rflip_reg;
            if (acc_reg != ACC_WORD || rflip_reg)
              cl_reg <= 1'b0;
          end
        end
        // data port write into input latches
        if (wr_hit)
        begin
          case (acc_reg)
            ACC_LSB:
            begin
              lo_reg <= IO_WDATA;
              hi_reg <= 8'h00;
            end
            ACC_MSB:
            begin
              lo_reg <= 8'h00;
              hi_reg <= IO_WDATA;
            end
            ACC_WORD:
            begin
              if (wflip_reg)
                hi_reg <= IO_WDATA;
              else
                lo_reg <= IO_WDATA;
              wflip_reg <= !wflip_reg;
            end
            default:
            begin
              lo_reg <= lo_reg;
            end
          endcase
          if (write_done)
            prog_reg <= 1'b1;
        end
        // counter latch command, first one wins
        if (latch_cmd && !cl_reg)
        begin
          ol_reg <= count_reg;
          cl_reg <= 1'b1;
        end
        // read-back: capture count and status if not already held
        if (rb_hit)
        begin
          if (!IO_WDATA[RB_COUNT_N_BIT] && !cl_reg)
          begin
            ol_reg <= count_reg;
            cl_reg <= 1'b1;
          end
          if (!IO_WDATA[RB_STATUS_N_BIT] && !sl_reg)
          begin
            st_reg <= {out_reg, null_reg, acc_reg, mode_reg, bcd_reg};
            sl_reg <= 1'b1;
          end
        end
        // new control word reprograms and releases the latches
        if (prog_cw)
        begin
          mode_reg <= norm_mode(IO_WDATA[CW_MODE_LO +: 3]);
          bcd_reg <= IO_WDATA[CW_BCD_BIT];
          acc_reg <= cw_acc;
          wflip_reg <= 1'b0;
          rflip_reg <= 1'b0;
          prog_reg <= 1'b0;
          cl_reg <= 1'b0;
          sl_reg <= 1'b0;
        end
      end
    end

    // decrement size; square wave takes odd counts in two uneven halves
    always_comb
    begin
      step = 2'h1;
      reload_pt = 16'h0001;
      if (mode_reg == MODE_SQUARE)
      begin
        if (count_reg[0])
          step = out_reg ? 2'h1 : 2'h3;
        else
          step = 2'h2;
        reload_pt = {14'h0000, step};
      end
    end

    assign nxt = ce_sub(count_reg, bcd_reg, step);

    // load decision on the tick falling edge
    always_comb
    begin
      load_now = 1'b0;
      case (mode_reg)
        MODE_TC, MODE_SWSTROBE:
          load_now = newc_reg;
        MODE_ONESHOT, MODE_HWSTROBE:
          load_now = trig_reg && prog_reg;
        MODE_RATE, MODE_SQUARE:
          load_now = (newc_reg && !run_reg) || (trig_reg && prog_reg)
            || (run_reg && gate_en && count_reg == reload_pt);
        default:
          load_now = 1'b0;
      endcase
      load_now = load_now && tick_fall;
    end

    // decrement when loaded and enabled
    always_comb
    begin
      dec_now = 1'b0;
      if (tick_fall && !load_now && run_reg)
      begin
        if (mode_reg == MODE_ONESHOT)
          dec_now = 1'b1;
        else
          dec_now = gate_en;
      end
    end

    // gate sampling and trigger flip-flop
    always_ff @(posedge CLK)
    begin
      if (SYS_RST)
      begin
        gpre_reg <= 1'b0;
        gate_s_reg <= 1'b0;
        tpend_reg <= 1'b0;
        trig_reg <= 1'b0;
      end
      else
      begin
        gpre_reg <= gate_raw;
        if (tick_fall)
          trig_reg <= 1'b0;
        if (tick_rise)
        begin
          gate_s_reg <= gate_raw;
          trig_reg <= tpend_reg;
          tpend_reg <= 1'b0;
        end
        if (gate_raw && !gpre_reg)
          tpend_reg <= 1'b1;
        if (prog_cw)
          trig_reg <= 1'b0;
      end
    end

    // counting element, output and flags
    always_ff @(posedge CLK)
    begin
      if (SYS_RST)
      begin
        count_reg <= RST_COUNT;
        out_reg <= RST_OUT;
        null_reg <= 1'b0;
        newc_reg <= 1'b0;
        run_reg <= 1'b0;
        armed_reg <= 1'b0;
      end
      else
      begin
        if (load_now)
        begin
          count_reg <= {hi_reg, lo_reg};
          null_reg <= 1'b0;
          newc_reg <= 1'b0;
          run_reg <= 1'b1;
          armed_reg <= 1'b1;
          case (mode_reg)
            MODE_TC, MODE_ONESHOT:
              out_reg <= 1'b0;
            MODE_SQUARE:
              out_reg <= (trig_reg || !run_reg) ? 1'b1 : !out_reg;
            default:
              out_reg <= 1'b1;
          endcase
        end
        else if (dec_now)
        begin
          count_reg <= nxt;
          case (mode_reg)
            MODE_TC, MODE_ONESHOT:
            begin
              if (nxt == 16'h0000)
                out_reg <= 1'b1;
            end
            MODE_RATE:
            begin
              if (nxt == 16'h0001)
                out_reg <= 1'b0;
            end
            MODE_SWSTROBE, MODE_HWSTROBE:
            begin
              out_reg <= !(nxt == 16'h0000 && armed_reg);
              if (nxt == 16'h0000)
                armed_reg <= 1'b0;
            end
            default:
              out_reg <= out_reg;
          endcase
        end
        // low gate holds counter 2 rate and square outputs high
        if ((mode_reg == MODE_RATE || mode_reg == MODE_SQUARE) && (i == 2) && !gate_raw)
          out_reg <= 1'b1;
        // control word sets the initial output level
        if (prog_cw)
        begin
          out_reg <= (IO_WDATA[CW_MODE_LO +: 3] != 3'b000);
          run_reg <= 1'b0;
          armed_reg <= 1'b0;
          newc_reg <= 1'b0;
          null_reg <= 1'b1;
        end
        // completed count write, set wins over load
        if (write_done)
        begin
          newc_reg <= 1'b1;
          null_reg <= 1'b1;
          if (mode_reg == MODE_TC)
            out_reg <= 1'b0;
        end
      end
    end

    // read data: status, frozen latches or live count
    assign src = cl_reg ? ol_reg : count_reg;
    always_comb
    begin
      if (sl_reg)
        rd_byte[i] = st_reg;
      else if (acc_reg == ACC_MSB)
        rd_byte[i] = src[15:8];
      else if (acc_reg == ACC_WORD && rflip_reg)
        rd_byte[i] = src[15:8];
      else
        rd_byte[i] = src[7:0];
    end
    assign out_w[i] = out_reg;
  end

  // ----------------------------------------
  // read return and outputs
  // ----------------------------------------
  // registered read data, one clk after the strobe
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      IO_RDATA <= 8'h00;
      IO_RACK <= 1'b0;
    end
    else
    begin
      IO_RACK <= IO_RD && (IO_ADDR[15:2] == CTR0_PORT[15:2]);
      if (IO_RD && IO_ADDR == CTR0_PORT)
        IO_RDATA <= rd_byte[0];
      else if (IO_RD && IO_ADDR == CTR1_PORT)
        IO_RDATA <= rd_byte[1];
      else if (IO_RD && IO_ADDR == CTR2_PORT)
        IO_RDATA <= rd_byte[2];
      else
        IO_RDATA <= 8'h00;
    end
  end

  assign COUNTER0_OUTPUT = out_w[0];
  assign COUNTER1_OUTPUT = out_w[1];
  assign COUNTER2_OUTPUT = out_w[2];

endmodule
`default_nettype wire

// [tb/pit_osc_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pit_osc_model
#(
  parameter int HALF = 2
)
(
  input wire logic clk,
  input wire logic rst,
  output logic osc
);
  // ----------------------------------------
  // oscillator source
  // ----------------------------------------
  int phase; // clocks spent in the current half period

  // square wave well below clk/2; held low in reset so the first rise is clean
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase <= 0;
      osc <= 1'b0;
    end
    else if (phase == HALF - 1)
    begin
      phase <= 0;
      osc <= !osc;
    end
    else
      phase <= phase + 1;
  end
endmodule
`default_nettype wire

// [tb/pit_top_props.sv]
`timescale 1ns/10ps
`default_nettype none
module pit_top_props
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic OSCILLATOR_INPUT,
  input wire logic [pit_pkg::ADDR_W-1:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  input wire logic [7:0] IO_RDATA,
  input wire logic IO_RACK,
  input wire logic COUNTER2_GATE,
  input wire logic COUNTER0_OUTPUT,
  input wire logic COUNTER1_OUTPUT,
  input wire logic COUNTER2_OUTPUT,
  input wire logic TIMER_TICK_CLOCK
);
  import pit_pkg::*;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic osc_q; // oscillator one clock ago
  logic tick_q; // tick one clock ago
  logic [3:0] osc_cnt; // oscillator rises since the tick last changed
  logic [3:0] evt_age; // clocks since a tick fall or a write
  logic rd_hit; // read aimed at a decoded port
  assign rd_hit = IO_RD && (IO_ADDR >= CTR0_PORT) && (IO_ADDR <= CTRL_PORT);

  // level history
  always_ff @(posedge CLK)
  begin
    osc_q <= SYS_RST ? 1'b0 : OSCILLATOR_INPUT;
    tick_q <= SYS_RST ? 1'b0 : TIMER_TICK_CLOCK;
  end

  // rises counted per tick half period
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || tick_q != TIMER_TICK_CLOCK)
      osc_cnt <= 4'h0;
    else if (OSCILLATOR_INPUT && !osc_q && osc_cnt != 4'hf)
      osc_cnt <= osc_cnt + 4'h1;
  end

  // outputs of counters 0 and 1 may only move shortly after one of these
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || IO_WR || (tick_q && !TIMER_TICK_CLOCK))
      evt_age <= 4'h0;
    else if (evt_age != 4'hf)
      evt_age <= evt_age + 4'h1;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_read_answered: assert property (rd_hit |=> IO_RACK)
    else $error("decoded read not answered");
  a_no_stray_ack: assert property (!rd_hit |=> !IO_RACK)
    else $error("answer without decoded read");
  a_ctrl_reads_zero: assert property (IO_RD && IO_ADDR == CTRL_PORT |=> IO_RDATA == 8'h00)
    else $error("control port read not zero");
  a_tick_six_edges: assert property (tick_q != TIMER_TICK_CLOCK |-> osc_cnt == 4'h6)
    else $error("tick half period not six oscillator rises");
  a_tick_not_late: assert property (osc_cnt <= 4'h6)
    else $error("tick missed its toggle");
  a_counter0_output_on_event: assert property ($changed(COUNTER0_OUTPUT) |-> evt_age <= 4'h4)
    else $error("counter 0 output moved without tick fall or write");
  a_out1_on_event: assert property ($changed(COUNTER1_OUTPUT) |-> evt_age <= 4'h4)
    else $error("counter 1 output moved without tick fall or write");
  a_reset_quiet: assert property ($fell(SYS_RST) |-> !IO_RACK && !TIMER_TICK_CLOCK)
    else $error("answer or tick active out of reset");
endmodule

bind pit_top pit_top_props i_pit_top_props (.CLK(CLK), .SYS_RST(SYS_RST),
  .OSCILLATOR_INPUT(OSCILLATOR_INPUT), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
  .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RACK(IO_RACK), .COUNTER2_GATE(COUNTER2_GATE),
  .COUNTER0_OUTPUT(COUNTER0_OUTPUT), .COUNTER1_OUTPUT(COUNTER1_OUTPUT),
  .COUNTER2_OUTPUT(COUNTER2_OUTPUT), .TIMER_TICK_CLOCK(TIMER_TICK_CLOCK));
`default_nettype wire

// [tb/test_triple_programmable_interval_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module test_triple_programmable_interval_timer;
  import pit_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk, sys_rst, osc, io_wr, io_rd, io_rack, counter2_gate, counter0_output, out1, counter2_output, tick;
  logic [ADDR_W-1:0] io_addr; // host port address
  logic [7:0] io_wdata, io_rdata;
  int fails = 0;
  int num_checks = 0;

  pit_top i_pit_top (.CLK(clk), .SYS_RST(sys_rst), .OSCILLATOR_INPUT(osc), .IO_ADDR(io_addr),
    .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_RACK(io_rack),
    .COUNTER2_GATE(counter2_gate), .COUNTER0_OUTPUT(counter0_output), .COUNTER1_OUTPUT(out1),
    .COUNTER2_OUTPUT(counter2_output), .TIMER_TICK_CLOCK(tick));
  pit_osc_model i_pit_osc_model (.clk(clk), .rst(sys_rst), .osc(osc));

  // 125 MHz clock
  always #4 clk = !clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one write strobe per byte
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask

  // read strobe, answer taken one clock after the strobe edge
  task automatic rd(input logic [15:0] a, input logic hit, output logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    @(posedge clk);
    d = io_rdata;
    check({15'h0000, io_rack}, {15'h0000, hit}, "read answer");
  endtask

  // low byte then high byte
  task automatic rd16(input logic [15:0] a, output logic [15:0] w);
    logic [7:0] lo, hi;
    rd(a, 1'b1, lo);
    rd(a, 1'b1, hi);
    w = {hi, lo};
  endtask

  // wait for a tick fall, then let registered outputs settle
  task automatic wait_fall;
    logic p;
    int n;
    p = tick;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (p === 1'b1 && tick === 1'b0)
        break;
      p = tick;
    end
    check(n < 200, 16'h0001, "tick fall seen");
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ports;
    logic [7:0] d;
    rd(16'h0044, 1'b0, d);
    rd(CTRL_PORT, 1'b1, d);
    check({8'h00, d}, 16'h0000, "control port reads zero");
    $display("test ports done");
  endtask

  task automatic t_terminal;
    logic [15:0] w;
    int first;
    first = 0;
    wait_fall();
    wr(CTRL_PORT, 8'hb0);
    wr(CTR2_PORT, 8'h03);
    wr(CTR2_PORT, 8'h00);
    check({15'h0000, counter2_output}, 16'h0000, "low after programming");
    for (int k = 1; k <= 5; k++)
    begin
      wait_fall();
      if (first == 0 && counter2_output === 1'b1)
        first = k;
    end
    check(first[15:0], 16'h0004, "rise after count plus one");
    wr(CTRL_PORT, 8'h80);
    wait_fall();
    wr(CTRL_PORT, 8'h80);
    rd16(CTR2_PORT, w);
    check(w, 16'hffff, "wrapped first snapshot");
    check({15'h0000, counter2_output}, 16'h0001, "stays high");
    $display("test terminal done");
  endtask

  task automatic t_zero_max;
    logic [15:0] w;
    for (int b = 0; b < 2; b++)
    begin
      wait_fall();
      wr(CTRL_PORT, {7'b1011000, b[0]});
      wr(CTR2_PORT, 8'h00);
      wr(CTR2_PORT, 8'h00);
      wait_fall();
      wait_fall();
      wr(CTRL_PORT, 8'h80);
      rd16(CTR2_PORT, w);
      check(w, b[0] ? 16'h9999 : 16'hffff, "zero loads maximum");
    end
    $display("test zero done");
  endtask

  task automatic t_readback;
    logic [7:0] d;
    logic [15:0] w;
    logic [8:0] p;
    wait_fall();
    wr(CTRL_PORT, 8'h76);
    wr(CTR1_PORT, 8'h05);
    wr(CTR1_PORT, 8'h00);
    wr(CTRL_PORT, 8'hc4);
    wr(CTRL_PORT, 8'hc4);
    rd(CTR1_PORT, 1'b1, d);
    check({8'h00, d}, 16'h00f6, "status with null set");
    rd16(CTR1_PORT, w);
    wait_fall();
    wr(CTRL_PORT, 8'he4);
    rd(CTR1_PORT, 1'b1, d);
    check({8'h00, d}, 16'h00b6, "status after load");
    for (int k = 0; k < 9; k++)
    begin
      wait_fall();
      p[k] = out1;
    end
    check({7'h00, p}, 16'h0073, "odd square wave shape");
    $display("test readback done");
  endtask

  task automatic t_gate;
    wait_fall();
    wr(CTRL_PORT, 8'hb6);
    wr(CTR2_PORT, 8'h04);
    wr(CTR2_PORT, 8'h00);
    for (int k = 0; k < 4 && counter2_output !== 1'b0; k++)
      wait_fall();
    check({15'h0000, counter2_output}, 16'h0000, "square low half");
    counter2_gate <= 1'b0;
    repeat (3) @(posedge clk);
    check({15'h0000, counter2_output}, 16'h0001, "low gate forces high");
    wait_fall();
    counter2_gate <= 1'b1;
    wait_fall();
    wait_fall();
    check({15'h0000, counter2_output}, 16'h0001, "high half after trigger");
    wait_fall();
    check({15'h0000, counter2_output}, 16'h0000, "low half after trigger");
    wr(CTRL_PORT, 8'h32);
    wr(CTR0_PORT, 8'h02);
    wr(CTR0_PORT, 8'h00);
    repeat (3) wait_fall();
    check({15'h0000, counter0_output}, 16'h0001, "tied gate never starts");
    $display("test gate done");
  endtask

  // rate, software strobe and hardware strobe side by side
  task automatic t_rate;
    logic [5:0] p0, p1, p2;
    wait_fall();
    wr(CTRL_PORT, 8'hba);
    wr(CTR2_PORT, 8'h02);
    wr(CTR2_PORT, 8'h00);
    counter2_gate <= 1'b0;
    @(posedge clk);
    counter2_gate <= 1'b1;
    wr(CTRL_PORT, 8'h74);
    wr(CTR1_PORT, 8'h03);
    wr(CTR1_PORT, 8'h00);
    wr(CTRL_PORT, 8'h38);
    wr(CTR0_PORT, 8'h02);
    wr(CTR0_PORT, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      wait_fall();
      p0[k] = counter0_output;
      p1[k] = out1;
      p2[k] = counter2_output;
    end
    check({10'h000, p1}, 16'h001b, "rate divides by three");
    check({10'h000, p0}, 16'h003b, "software strobe one tick low");
    check({10'h000, p2}, 16'h003b, "hardware strobe one tick low");
    $display("test rate done");
  endtask

  // ----------------------------------------
  // ending
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog far beyond the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end

  // main sequence
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    io_addr = '0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    counter2_gate = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_ports();
    t_terminal();
    t_zero_max();
    t_readback();
    t_gate();
    t_rate();
    results();
  end
endmodule
`default_nettype wire
